// ===== hdl/qdc_regs.svh
// register offsets, field positions, reset values and timing counts of the decoder
// assumes inclusion by bare name from the design file and the testbench
`ifndef QDC_REGS_SVH
`define QDC_REGS_SVH
// printed offsets are not all multiples of four: these are indices, byte address = 4 * index
`define QDC_IDX_STATUS 8'h90
`define QDC_IDX_CTRL 8'h91
`define QDC_IDX_CNT1 8'h94
`define QDC_IDX_CNT2 8'h96
`define QDC_IDX_TICKDIV 8'h98
`define QDC_IDX_IRQ_MASK 8'h99
// control fields
`define QDC_CTRL_SEL2_HI 7
`define QDC_CTRL_SEL2_LO 6
`define QDC_CTRL_SEL1_HI 3
`define QDC_CTRL_SEL1_LO 2
`define QDC_CTRL_PRIO_HI 1
`define QDC_CTRL_PRIO_LO 0
// status fields
`define QDC_ST_UP2 7
`define QDC_ST_DN2 6
`define QDC_ST_CLR2 4
`define QDC_ST_UP1 3
`define QDC_ST_DN1 2
`define QDC_ST_CLR1 0
// reset values
`define QDC_CTRL_RST 8'h00
`define QDC_CNT_RST 8'h00
`define QDC_MASK_RST 8'hCC
`define QDC_TICKDIV_RST 8'h01
// peripheral clock period and minimum tick spacing
`define QDC_CLK_NS 10
`define QDC_TICK_MIN_NS 20
`define QDC_TICK_MIN_CYC ((`QDC_TICK_MIN_NS + `QDC_CLK_NS - 1) / `QDC_CLK_NS)
`endif

// ===== hdl/qdc_pkg.sv
// types shared by the quadrature decoder control block
// assumes nothing beyond the constants header
package qdc_pkg;
  // selector codes of one channel
  typedef enum logic [1:0] {
    QDC_SEL_OFF0,
    QDC_SEL_OFF1,
    QDC_SEL_LOW,
    QDC_SEL_HIGH
  } qdc_sel_e;
  // apb slave phase
  typedef enum logic [0:0] {
    QDC_BUS_IDLE,
    QDC_BUS_DONE
  } qdc_bus_e;
  typedef logic [7:0] qdc_byte_t;
endpackage : qdc_pkg

// ===== hdl/qdc_top.sv
// two-channel quadrature decoder with apb register access and interrupt
// assumes an apb master on I_REF_CLK; port pins are asynchronous to the clock
//
// Summary of operation
// - ch2 select: 0x off, 10 bits3:2, 11 bits7:6
// - ch2 selector changes hold its counter only in the write cycle
// - ch1 select: 0x off, 10 bits1:0, 11 bits5:4
// - ch1 selector changes hold its counter only in the write cycle
// - control bits 5:4 ignored
// - bits 1:0 give interrupt priority, 00 off
// - count registers read present 8-bit counts
// - step away from zero (up or down) sets flag, raises interrupt
// - status read clears flags and interrupt
// - filter rejects pulses under one tick
// - sample and count only on tick
`timescale 1ns/1ps
`default_nettype none
`include "qdc_regs.svh"
module qdc_top (
  // clock and reset
  input wire logic I_REF_CLK,
  input wire logic I_RSTN,
  // apb slave
  input wire logic I_PSEL,
  input wire logic I_PENABLE,
  input wire logic I_PWRITE,
  input wire logic [11:0] I_PADDR,
  input wire logic [31:0] I_PWDATA,
  output logic O_PREADY,
  output logic O_PSLVERR,
  output logic [31:0] O_PRDATA,
  // encoder port pins
  input wire logic [7:0] I_PORT,
  // interrupt
  output logic O_IRQ,
  output logic [1:0] O_IRQ_PRIO
);

  // two-flop synchroniser on the port pins
  logic [7:0] sync1_q, sync2_q;
  // registers
  logic [7:0] ctrl_q, ctrl_d;
  logic [7:0] mask_q;
  logic [7:0] div_q;
  logic [7:0] status_q;
  logic [7:0] tick_cnt_q;
  logic tick_q;
  // filter state per phase line: ch1 i,q then ch2 i,q
  logic [3:0] raw_prev_q;
  logic [3:0] filt_q;
  logic [7:0] cnt1_q, cnt2_q;
  // apb phase
  qdc_pkg::qdc_bus_e bus_q;

  // step direction from two gray samples: +1, -1 or none
  function automatic logic [1:0] qdc_step(input logic [1:0] prev, input logic [1:0] cur);
    logic [1:0] res;
    res = 2'h0;
    // order 00 -> 01 -> 11 -> 10 is upward (i is the high bit)
    case ({prev, cur})
      4'h1, 4'h7, 4'hE, 4'h8: res = 2'h1;  // up
      4'h2, 4'hB, 4'hD, 4'h4: res = 2'h2;  // down
      default: res = 2'h0;                 // no move or invalid double step
    endcase
    return res;
  endfunction : qdc_step

  // channel input selection; disabled channels park at 00 for i/q
  function automatic logic [1:0] qdc_pick(input logic [1:0] sel, input logic [1:0] lo,
                                          input logic [1:0] hi);
    logic [1:0] res;
    res = 2'h0;
    case (qdc_pkg::qdc_sel_e'(sel))
      qdc_pkg::QDC_SEL_LOW: res = lo;
      qdc_pkg::QDC_SEL_HIGH: res = hi;
      default: res = 2'h0;
    endcase
    return res;
  endfunction : qdc_pick

  // bus decode
  wire [9:0] idx = I_PADDR[11:2];
  wire setup = I_PSEL && !I_PENABLE;
  // writes land at the ready edge of the access phase, when the master samples the answer
  wire wr = I_PSEL && I_PENABLE && O_PREADY && I_PWRITE;
  wire rd = setup && !I_PWRITE;
  wire hit_st = (idx == {2'h0, `QDC_IDX_STATUS});
  wire hit_ctrl = (idx == {2'h0, `QDC_IDX_CTRL});
  wire hit_c1 = (idx == {2'h0, `QDC_IDX_CNT1});
  wire hit_c2 = (idx == {2'h0, `QDC_IDX_CNT2});
  wire hit_div = (idx == {2'h0, `QDC_IDX_TICKDIV});
  wire hit_mask = (idx == {2'h0, `QDC_IDX_IRQ_MASK});
  wire hit_any = hit_st | hit_ctrl | hit_c1 | hit_c2 | hit_div | hit_mask;
  wire aligned = (I_PADDR[1:0] == 2'h0);
  wire bad = !hit_any || !aligned;

  // writes to the ignored field are dropped so it always stores zero
  always_comb begin
    ctrl_d = ctrl_q;
    if (wr && hit_ctrl && !bad) begin
      ctrl_d = I_PWDATA[7:0] & 8'hCF;
    end
  end

  // read mux; status has reset-strobe bits reading as zero
  wire [7:0] st_view = status_q & 8'hCC;
  wire [7:0] rd_mux = hit_st ? st_view :
                      hit_ctrl ? ctrl_q :
                      hit_c1 ? cnt1_q :
                      hit_c2 ? cnt2_q :
                      hit_div ? div_q :
                      hit_mask ? mask_q : 8'h00;
  wire st_read = rd && hit_st && !bad;
  wire clr1 = wr && hit_st && !bad && I_PWDATA[`QDC_ST_CLR1];
  wire clr2 = wr && hit_st && !bad && I_PWDATA[`QDC_ST_CLR2];

  // tick: divider with floor of two clocks so tick never exceeds half clock
  wire [7:0] div_eff = (div_q < 8'(`QDC_TICK_MIN_CYC - 1)) ? 8'(`QDC_TICK_MIN_CYC - 1) : div_q;
  wire tick_wrap = (tick_cnt_q >= div_eff);

  // filtering: a line changes only after two equal ticked samples
  wire [3:0] raw = {qdc_pick(ctrl_q[`QDC_CTRL_SEL2_HI:`QDC_CTRL_SEL2_LO],
                             sync2_q[3:2], sync2_q[7:6]),
                    qdc_pick(ctrl_q[`QDC_CTRL_SEL1_HI:`QDC_CTRL_SEL1_LO],
                             sync2_q[1:0], sync2_q[5:4])};
  wire [3:0] filt_n = (raw == raw_prev_q) ? raw : filt_q;
  // a selector write moves the raw samples; counting is skipped in the write cycle only, the filter is not re-seeded
  wire sel_chg1 = (ctrl_d[3:2] != ctrl_q[3:2]);
  wire sel_chg2 = (ctrl_d[7:6] != ctrl_q[7:6]);
  wire [1:0] st1 = qdc_step(filt_q[1:0], filt_n[1:0]);
  wire [1:0] st2 = qdc_step(filt_q[3:2], filt_n[3:2]);
  wire up1 = tick_q && st1 == 2'h1;
  wire dn1 = tick_q && st1 == 2'h2;
  wire up2 = tick_q && st2 == 2'h1;
  wire dn2 = tick_q && st2 == 2'h2;
  // step away from zero events
  wire ev_up1 = up1 && cnt1_q == 8'h00 && !clr1;
  wire ev_dn1 = dn1 && cnt1_q == 8'h00 && !clr1;
  wire ev_up2 = up2 && cnt2_q == 8'h00 && !clr2;
  wire ev_dn2 = dn2 && cnt2_q == 8'h00 && !clr2;
  wire [7:0] ev = {ev_up2, ev_dn2, 2'h0, ev_up1, ev_dn1, 2'h0};
  // read clears, but an event in the same cycle still sets
  wire [7:0] status_d = (st_read ? 8'h00 : status_q) | ev;
  wire irq_d = |(status_d & mask_q) && (ctrl_d[1:0] != 2'h0);

  // synchroniser
  always_ff @(posedge I_REF_CLK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      sync1_q <= 8'h00;
      sync2_q <= 8'h00;
    end else begin
      sync1_q <= I_PORT;
      sync2_q <= sync1_q;
    end
  end

  // tick generator
  always_ff @(posedge I_REF_CLK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      tick_cnt_q <= 8'h00;
      tick_q <= 1'b0;
    end else begin
      tick_cnt_q <= tick_wrap ? 8'h00 : tick_cnt_q + 8'h01;
      tick_q <= tick_wrap;
    end
  end

  // filter sampling only on tick
  always_ff @(posedge I_REF_CLK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      raw_prev_q <= 4'h0;
      filt_q <= 4'h0;
    end else if (tick_q) begin
      raw_prev_q <= raw;
      filt_q <= filt_n;
    end
  end

  // channel one counter; selector change or clear strobe blocks a step
  always_ff @(posedge I_REF_CLK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      cnt1_q <= `QDC_CNT_RST;
    end else if (clr1) begin
      cnt1_q <= `QDC_CNT_RST;
    end else if (sel_chg1) begin
      cnt1_q <= cnt1_q;
    end else if (up1) begin
      cnt1_q <= cnt1_q + 8'h01;
    end else if (dn1) begin
      cnt1_q <= cnt1_q - 8'h01;
    end
  end

  // channel two counter
  always_ff @(posedge I_REF_CLK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      cnt2_q <= `QDC_CNT_RST;
    end else if (clr2) begin
      cnt2_q <= `QDC_CNT_RST;
    end else if (sel_chg2) begin
      cnt2_q <= cnt2_q;
    end else if (up2) begin
      cnt2_q <= cnt2_q + 8'h01;
    end else if (dn2) begin
      cnt2_q <= cnt2_q - 8'h01;
    end
  end

  // software registers and status
  always_ff @(posedge I_REF_CLK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      ctrl_q <= `QDC_CTRL_RST;
      mask_q <= `QDC_MASK_RST;
      div_q <= `QDC_TICKDIV_RST;
      status_q <= 8'h00;
      O_IRQ <= 1'b0;
      O_IRQ_PRIO <= 2'h0;
    end else begin
      ctrl_q <= ctrl_d;
      if (wr && hit_mask && !bad) begin
        mask_q <= I_PWDATA[7:0];
      end
      if (wr && hit_div && !bad) begin
        div_q <= I_PWDATA[7:0];
      end
      status_q <= status_d;
      O_IRQ <= irq_d;
      O_IRQ_PRIO <= ctrl_d[1:0];
    end
  end

  // apb: answer one cycle after setup, in the access phase
  always_ff @(posedge I_REF_CLK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      bus_q <= qdc_pkg::QDC_BUS_IDLE;
      O_PREADY <= 1'b0;
      O_PSLVERR <= 1'b0;
      O_PRDATA <= 32'h0000_0000;
    end else begin
      case (bus_q)
        qdc_pkg::QDC_BUS_IDLE: begin
          if (setup) begin
            bus_q <= qdc_pkg::QDC_BUS_DONE;
            O_PREADY <= 1'b1;
            O_PSLVERR <= bad;
            O_PRDATA <= (rd && !bad) ? {24'h00_0000, rd_mux} : 32'h0000_0000;
          end
        end
        qdc_pkg::QDC_BUS_DONE: begin
          bus_q <= qdc_pkg::QDC_BUS_IDLE;
          O_PREADY <= 1'b0;
          O_PSLVERR <= 1'b0;
        end
        default: bus_q <= qdc_pkg::QDC_BUS_IDLE;
      endcase
    end
  end

endmodule : qdc_top
`default_nettype wire

// ===== tb/qdc_top_sva.sv
// port checks of the decoder: bus answers, readback and interrupt line
// assumes one clock and the async active-low reset of qdc_top
`timescale 1ns/1ps
`default_nettype none
module qdc_top_sva (
  // clock, reset and bus request
  input wire logic I_REF_CLK,
  input wire logic I_RSTN,
  input wire logic I_PSEL,
  input wire logic I_PENABLE,
  input wire logic I_PWRITE,
  input wire logic [11:0] I_PADDR,
  input wire logic [31:0] I_PWDATA,
  // answers and interrupt
  input wire logic O_PREADY,
  input wire logic O_PSLVERR,
  input wire logic [31:0] O_PRDATA,
  input wire logic O_IRQ,
  input wire logic [1:0] O_IRQ_PRIO
);
  default clocking cb @(posedge I_REF_CLK); endclocking
  default disable iff (!I_RSTN);
  // setup cycle and decoded targets
  wire setup = I_PSEL && !I_PENABLE;
  wire mapped = I_PADDR inside {12'h240, 12'h244, 12'h250, 12'h258, 12'h260, 12'h264};
  wire ctrl_hit = setup && I_PADDR == 12'h244;
  wire st_rd = setup && !I_PWRITE && I_PADDR == 12'h240;
  wire [1:0] wprio = I_PWDATA[1:0]; // priority field of write data
  a_ready_next: assert property (setup |=> O_PREADY)
    else $error("no ready after setup");
  a_err_unmapped: assert property (setup && !mapped |=> O_PSLVERR && O_PRDATA == 32'h0)
    else $error("unmapped access not refused");
  a_upper_zero: assert property (O_PREADY |-> O_PRDATA[31:8] == 24'h0)
    else $error("upper read bits set");
  a_ctrl_ignored: assert property (ctrl_hit && !I_PWRITE |=> O_PRDATA[5:4] == 2'h0)
    else $error("ignored control bits read back");
  a_prio_write: assert property (ctrl_hit && I_PWRITE |-> ##2 O_IRQ_PRIO == $past(wprio, 2))
    else $error("priority not taken");
  a_irq_off: assert property (O_IRQ_PRIO == 2'h0 && $past(O_IRQ_PRIO) == 2'h0 |-> !O_IRQ)
    else $error("interrupt with priority off");
  a_irq_clear: assert property (st_rd |-> ##[1:2] !O_IRQ)
    else $error("status read kept interrupt");
  a_irq_rise: assert property ($rose(O_IRQ) |-> O_IRQ_PRIO != 2'h0)
    else $error("interrupt rose with priority off");
  c_refused: cover property (setup && !mapped);
  c_irq_up: cover property ($rose(O_IRQ));
  c_irq_down: cover property ($fell(O_IRQ));
endmodule : qdc_top_sva
bind qdc_top qdc_top_sva i_qdc_top_sva (.I_REF_CLK(I_REF_CLK), .I_RSTN(I_RSTN),
  .I_PSEL(I_PSEL), .I_PENABLE(I_PENABLE), .I_PWRITE(I_PWRITE), .I_PADDR(I_PADDR),
  .I_PWDATA(I_PWDATA), .O_PREADY(O_PREADY), .O_PSLVERR(O_PSLVERR), .O_PRDATA(O_PRDATA),
  .O_IRQ(O_IRQ), .O_IRQ_PRIO(O_IRQ_PRIO));
`default_nettype wire

// ===== tb/qdc_enc_model.sv
// incremental encoder model: two phase lines stepping in gray order
// assumes one-cycle step and spike commands from the bench
`timescale 1ns/1ps
`default_nettype none
module qdc_enc_model (
  // clock and commands
  input wire logic i_clk,
  input wire logic i_up,
  input wire logic i_dn,
  input wire logic i_glitch,
  // phase lines, in-phase in bit 1
  output logic [1:0] o_iq
);
  logic [1:0] pos_q = 2'h0; // shaft position modulo four
  logic glitch_q = 1'b0; // one-cycle spike on the in-phase line
  // one state per command, changed just after the edge
  always_ff @(posedge i_clk) begin
    if (i_up) begin
      pos_q <= pos_q + 2'h1; // up order 00,01,11,10
    end else if (i_dn) begin
      pos_q <= pos_q - 2'h1; // reverse order
    end
    glitch_q <= i_glitch;
  end
  // spike is shorter than a tick, so a working filter drops it
  assign o_iq = {pos_q[1], pos_q[1] ^ pos_q[0]} ^ {glitch_q, 1'b0};
endmodule : qdc_enc_model
`default_nettype wire

// ===== tb/testbench.sv
// bench for qdc_top: apb tasks, one encoder model placed on either port nibble
// assumes the tick divider stays at reset, two clocks a tick
`timescale 1ns/1ps
`default_nettype none
`include "qdc_regs.svh"
module testbench;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic psel = 1'b0, pen = 1'b0, pwr = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rdv;
  logic pready, pslverr, irq, err;
  logic [1:0] prio, iq;
  logic up = 1'b0, dn = 1'b0, gl = 1'b0, place = 1'b0; // place 1: upper nibble
  int n_mismatch = 0;
  int samples_checked = 0;
  wire [7:0] port = place ? {iq, iq, 4'h0} : {4'h0, iq, iq};
  always #5 clk = ~clk;
  qdc_top i_qdc_top (.I_REF_CLK(clk), .I_RSTN(rstn), .I_PSEL(psel), .I_PENABLE(pen),
    .I_PWRITE(pwr), .I_PADDR(paddr), .I_PWDATA(pwdata), .O_PREADY(pready),
    .O_PSLVERR(pslverr), .O_PRDATA(prdata), .I_PORT(port), .O_IRQ(irq), .O_IRQ_PRIO(prio));
  qdc_enc_model i_qdc_enc_model (.i_clk(clk), .i_up(up), .i_dn(dn), .i_glitch(gl), .o_iq(iq));
  // counts, verdict, end of run
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : give_verdict
  // single comparison point
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  // one apb transfer; waits for ready, unbounded
  task automatic apb(input logic w, input logic [7:0] ix, input logic [31:0] wd);
    @(posedge clk);
    psel <= 1'b1;
    pwr <= w;
    paddr <= {2'h0, ix, 2'h0};
    pwdata <= wd;
    @(posedge clk);
    pen <= 1'b1;
    // wait for the answer however long it takes; only the watchdog ends a hang
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    rdv = prdata;
    err = pslverr;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask : apb
  // read and compare
  task automatic rdc(input logic [7:0] ix, input logic [31:0] ex);
    apb(1'b0, ix, 32'h0);
    chk(rdv, ex);
  endtask : rdc
  // encoder steps, spaced well beyond the filter's two ticks
  task automatic step(input logic u, input int n);
    repeat (n) begin
      @(posedge clk);
      up <= u;
      dn <= !u;
      @(posedge clk);
      up <= 1'b0;
      dn <= 1'b0;
      repeat (12) @(posedge clk);
    end
  endtask : step
  // watchdog far beyond the expected run of about five hundred cycles
  initial begin
    repeat (20000) @(posedge clk);
    n_mismatch++;
    give_verdict();
  end
  // main sequence
  initial begin
    repeat (10) @(posedge clk);
    rstn <= 1'b1;
    rdc(`QDC_IDX_CTRL, 32'h0);
    rdc(`QDC_IDX_CNT1, 32'h0);
    rdc(`QDC_IDX_IRQ_MASK, 32'hCC);
    rdc(8'h92, 32'h0);
    chk({31'h0, err}, 32'h1);
    for (int p = 0; p < 4; p++) begin
      apb(1'b1, `QDC_IDX_CTRL, 32'h30 | 32'(p));
      rdc(`QDC_IDX_CTRL, 32'(p));
      chk({30'h0, prio}, 32'(p));
    end
    place <= 1'b1;
    apb(1'b1, `QDC_IDX_CTRL, 32'hCE);
    step(1'b1, 4);
    rdc(`QDC_IDX_CNT1, 32'h4);
    rdc(`QDC_IDX_CNT2, 32'h4);
    chk({31'h0, irq}, 32'h1);
    rdc(`QDC_IDX_STATUS, 32'h88);
    repeat (2) @(posedge clk);
    chk({31'h0, irq}, 32'h0);
    rdc(`QDC_IDX_STATUS, 32'h0);
    apb(1'b1, `QDC_IDX_IRQ_MASK, 32'h0);
    step(1'b0, 8);
    rdc(`QDC_IDX_CNT1, 32'hFC);
    chk({31'h0, irq}, 32'h0);
    apb(1'b1, `QDC_IDX_IRQ_MASK, 32'hCC);
    repeat (2) @(posedge clk);
    chk({31'h0, irq}, 32'h1);
    rdc(`QDC_IDX_STATUS, 32'h44);
    gl <= 1'b1;
    @(posedge clk);
    gl <= 1'b0;
    repeat (12) @(posedge clk);
    rdc(`QDC_IDX_CNT1, 32'hFC);
    apb(1'b1, `QDC_IDX_CTRL, 32'hAA);
    rdc(`QDC_IDX_CNT1, 32'hFC);
    rdc(`QDC_IDX_CNT2, 32'hFC);
    step(1'b1, 4);
    rdc(`QDC_IDX_CNT1, 32'hFC);
    place <= 1'b0;
    step(1'b1, 4);
    rdc(`QDC_IDX_CNT1, 32'h0);
    rdc(`QDC_IDX_CNT2, 32'h0);
    rdc(`QDC_IDX_STATUS, 32'h0);
    apb(1'b1, `QDC_IDX_CTRL, 32'h02);
    step(1'b1, 4);
    rdc(`QDC_IDX_CNT1, 32'h0);
    rdc(`QDC_IDX_CNT2, 32'h0);
    give_verdict();
  end
endmodule : testbench
`default_nettype wire
